// >>> src/trxsp_pkg.sv
package trxsp_pkg;
    // bus geometry of the 64-bit receive port
    localparam int DATA_W = 64;
    localparam int BE_W = DATA_W / 8;
    localparam int BAR_W = 8;
    localparam int FUNC_W = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int VALID_DROP_MAX = 3;
    // header field positions in dword 0, dword 1 and the last header dword
    localparam int FMT_4DW_BIT = 29;
    localparam int FMT_DATA_BIT = 30;
    localparam int LEN_LSB = 0;
    localparam int LEN_W = 10;
    localparam int FBE_LSB = 0;
    localparam int LBE_LSB = 4;
    localparam int ADDR2_BIT = 2;
    // reset values
    localparam logic [BE_W-1:0] BE_RST = 8'h00;

    // one beat as it leaves the port
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [BE_W-1:0] be;
        logic sop;
        logic eop;
        logic [BAR_W-1:0] bar;
        logic [FUNC_W-1:0] func;
    } trxsp_beat_s;

    localparam int BEAT_W = $bits(trxsp_beat_s);
endpackage : trxsp_pkg

// >>> src/trxsp_fifo.sv
`timescale 1ns/100ps
module trxsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    // handshakes on both sides
    assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_ff[rd_ptr_ff];

    // storage
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // pointers and fill count
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : trxsp_fifo

// >>> src/trxsp_rx_port.sv
`timescale 1ns/100ps
module trxsp_rx_port
    import trxsp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // dword stream from the protocol core, one dword per cycle
    input wire logic [31:0] core_dword_i,
    input wire logic core_dword_valid_i,
    input wire logic core_dword_last_i,
    input wire logic [BAR_W-1:0] core_bar_i,
    input wire logic [FUNC_W-1:0] core_func_i,
    output logic core_dword_ready_o,
    // application side
    output logic [DATA_W-1:0] rx_payload_bus_o,
    output logic [BE_W-1:0] rx_byte_enables_o,
    output logic rx_beat_valid_o,
    output logic rx_first_beat_o,
    output logic rx_last_beat_o,
    output logic [BAR_W-1:0] rx_window_hit_vector_o,
    output logic [FUNC_W-1:0] rx_func_num_o,
    input wire logic rx_sink_ready_i
);
    typedef enum logic [2:0] {
        ST_HDR = 3'b001,
        ST_DATA = 3'b010,
        ST_PAD = 3'b100
    } trxsp_state_e;


    // packet parsing state
    trxsp_state_e state_ff;
    logic [2:0] hdr_idx_ff;
    logic hdr4_ff;
    logic has_data_ff;
    logic [LEN_W-1:0] dw_left_ff;
    logic [3:0] fbe_ff;
    logic [3:0] lbe_ff;

    // lane pairing of dwords into beats
    logic first_dw_ff;
    logic lane_ff;
    logic [31:0] low_dw_ff;
    logic [3:0] low_be_ff;
    logic low_full_ff;
    logic pkt_start_ff;
    logic [BAR_W-1:0] bar_ff;
    logic [FUNC_W-1:0] func_ff;

    // beat buffer and output stage
    trxsp_beat_s beat_in;
    logic beat_push;
    logic fifo_in_ready;
    trxsp_beat_s fifo_out;
    logic fifo_out_valid;
    logic fifo_pop;
    logic out_full_ff;
    logic accept;

    // combinational helpers
    logic take;
    logic [3:0] cur_be;
    logic dw_is_last;
    logic hdr_end;

    // byte enable of one data dword from the header fields
    function automatic logic [3:0] dw_be(input logic first, input logic last,
                                        input logic [3:0] fbe, input logic [3:0] last_byte_enable_field);
        logic [3:0] r;
        r = 4'hF;
        if (first) begin
            r = fbe;
        end else if (last) begin
            r = last_byte_enable_field;
        end
        return r;
    endfunction : dw_be

    // a dword is taken only when a beat can be emitted if it completes one
    assign take = core_dword_valid_i && fifo_in_ready && (state_ff != ST_PAD);
    assign core_dword_ready_o = fifo_in_ready && (state_ff != ST_PAD);
    assign dw_is_last = (dw_left_ff == LEN_W'(1));
    assign hdr_end = hdr4_ff ? (hdr_idx_ff == 3'd3) : (hdr_idx_ff == 3'd2);
    assign cur_be = dw_be(first_dw_ff, dw_is_last && !first_dw_ff, fbe_ff, lbe_ff);

    // assemble 64-bit beats, lower dword in lower bits
    always_comb begin
        beat_in = '0;
        beat_push = 1'b0;
        beat_in.bar = bar_ff;
        beat_in.func = func_ff;
        beat_in.sop = pkt_start_ff;
        if (state_ff == ST_PAD) begin
            beat_push = low_full_ff;
            beat_in.data = {32'h0000_0000, low_dw_ff};
            beat_in.be = {4'h0, low_be_ff};
            beat_in.eop = 1'b1;
        end else if (take) begin
            if (lane_ff) begin
                beat_push = 1'b1;
                beat_in.data = {core_dword_i, low_dw_ff};
                beat_in.be = (state_ff == ST_DATA) ? {cur_be, low_be_ff} : BE_RST;
                beat_in.eop = core_dword_last_i;
            end else if (core_dword_last_i) begin
                beat_push = 1'b1;
                beat_in.data = {32'h0000_0000, core_dword_i};
                beat_in.be = (state_ff == ST_DATA) ? {4'h0, cur_be} : BE_RST;
                beat_in.eop = 1'b1;
            end
        end
    end

    // header parsing and lane tracking
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_HDR;
            hdr_idx_ff <= '0;
            hdr4_ff <= 1'b0;
            has_data_ff <= 1'b0;
            dw_left_ff <= '0;
            fbe_ff <= '0;
            lbe_ff <= '0;
            first_dw_ff <= 1'b0;
            lane_ff <= 1'b0;
            low_dw_ff <= '0;
            low_be_ff <= '0;
            low_full_ff <= 1'b0;
            pkt_start_ff <= 1'b1;
            bar_ff <= '0;
            func_ff <= '0;
        end else if (state_ff == ST_PAD) begin
            if (fifo_in_ready) begin
                state_ff <= ST_HDR;
                lane_ff <= 1'b0;
                low_full_ff <= 1'b0;
                pkt_start_ff <= 1'b1;
                hdr_idx_ff <= '0;
            end
        end else if (take) begin
            if (!lane_ff) begin
                low_dw_ff <= core_dword_i;
                low_be_ff <= (state_ff == ST_DATA) ? cur_be : 4'h0;
                low_full_ff <= 1'b1;
            end else begin
                low_full_ff <= 1'b0;
            end
            if (beat_push) begin
                pkt_start_ff <= 1'b0;
            end
            lane_ff <= ~lane_ff;
            if (state_ff == ST_HDR) begin
                hdr_idx_ff <= hdr_idx_ff + 3'd1;
                if (hdr_idx_ff == 3'd0) begin
                    hdr4_ff <= core_dword_i[FMT_4DW_BIT];
                    has_data_ff <= core_dword_i[FMT_DATA_BIT];
                    dw_left_ff <= core_dword_i[LEN_LSB +: LEN_W];
                    bar_ff <= core_bar_i;
                    func_ff <= core_func_i;
                end
                if (hdr_idx_ff == 3'd1) begin
                    fbe_ff <= core_dword_i[FBE_LSB +: 4];
                    lbe_ff <= core_dword_i[LBE_LSB +: 4];
                end
                if (hdr_end && has_data_ff && !core_dword_last_i) begin
                    state_ff <= ST_DATA;
                    first_dw_ff <= 1'b1;
                    // unaligned 3-dword: data 0 follows in upper half
                    // aligned 4-dword: lane cleared, data 0 starts low with no pad
                    // a 3-dword header leaves dword two alone in the low lane, so data 0
                    // always pairs into the upper half; no pad is inserted there
                    if (hdr4_ff ? core_dword_i[ADDR2_BIT] == 1'b0 : 1'b0) begin
                        lane_ff <= 1'b0;
                    end
                end
            end else begin
                first_dw_ff <= 1'b0;
                dw_left_ff <= dw_left_ff - LEN_W'(1);
            end
            if (core_dword_last_i) begin
                if (beat_push) begin
                    state_ff <= ST_HDR;
                    lane_ff <= 1'b0;
                    low_full_ff <= 1'b0;
                    pkt_start_ff <= 1'b1;
                    hdr_idx_ff <= '0;
                end else begin
                    state_ff <= ST_PAD;
                end
            end
        end
    end

    trxsp_fifo #(
        .WIDTH(BEAT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .in_data_i(beat_in),
        .in_valid_i(beat_push),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop)
    );

    // a beat is handed over only when valid and ready meet at one edge
    assign accept = rx_beat_valid_o && rx_sink_ready_i;

    // output register loads only when empty or its beat is handed over
    assign fifo_pop = fifo_out_valid && (!out_full_ff || accept);

    // output register occupancy, independent of what valid shows
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_full_ff <= 1'b0;
        end else if (!out_full_ff || accept) begin
            out_full_ff <= fifo_out_valid;
        end
    end

    // valid follows last cycle's ready, so it falls one cycle after ready drops
    // while the held beat itself stays put until it is handed over
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_beat_valid_o <= 1'b0;
        end else begin
            rx_beat_valid_o <= ((out_full_ff && !accept) || fifo_pop) && rx_sink_ready_i;
        end
    end

    // output flip-flops, held while stalled
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_payload_bus_o <= '0;
            rx_byte_enables_o <= BE_RST;
            rx_first_beat_o <= 1'b0;
            rx_last_beat_o <= 1'b0;
            rx_window_hit_vector_o <= '0;
            rx_func_num_o <= '0;
        end else begin
            if (fifo_pop) begin
                rx_payload_bus_o <= fifo_out.data;
                rx_byte_enables_o <= fifo_out.be;
                rx_first_beat_o <= fifo_out.sop;
                rx_last_beat_o <= fifo_out.eop;
                rx_window_hit_vector_o <= fifo_out.bar;
                rx_func_num_o <= fifo_out.func;
            end
        end
    end
endmodule : trxsp_rx_port

// >>> sim/trxsp_rx_port_props.sv
`timescale 1ns/100ps
module trxsp_rx_port_props
    import trxsp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [DATA_W-1:0] rx_payload_bus_o,
    input wire logic [BE_W-1:0] rx_byte_enables_o,
    input wire logic rx_beat_valid_o,
    input wire logic rx_first_beat_o,
    input wire logic rx_last_beat_o,
    input wire logic [BAR_W-1:0] rx_window_hit_vector_o,
    input wire logic [FUNC_W-1:0] rx_func_num_o,
    input wire logic rx_sink_ready_i
);
    logic acc;
    logic in_pkt_ff;
    logic hdr4_ff;
    logic [1:0] idx_ff;
    logic [BAR_W-1:0] bar_ff;
    logic [FUNC_W-1:0] func_ff;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    assign acc = rx_beat_valid_o && rx_sink_ready_i;
    // packet position from accepted beats
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_pkt_ff <= 1'b0;
            idx_ff <= 2'd0;
        end else if (acc) begin
            in_pkt_ff <= !rx_last_beat_o;
            idx_ff <= rx_first_beat_o ? 2'd1 : idx_ff + {1'b0, idx_ff != 2'd3};
        end
    end
    // packet attributes seen on the first beat
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hdr4_ff <= 1'b0;
            bar_ff <= '0;
            func_ff <= '0;
        end else if (acc && rx_first_beat_o) begin
            hdr4_ff <= rx_payload_bus_o[FMT_4DW_BIT];
            bar_ff <= rx_window_hit_vector_o;
            func_ff <= rx_func_num_o;
        end
    end
    sequence s_stall;
        rx_beat_valid_o && !rx_sink_ready_i;
    endsequence
    sequence s_mid;
        rx_beat_valid_o && in_pkt_ff;
    endsequence
    a_sop_hdr_be: assert property (rx_beat_valid_o && rx_first_beat_o |-> !rx_byte_enables_o)
        else $error("be on first beat");
    a_valid_drop: assert property ((!rx_sink_ready_i)[*4] |-> !rx_beat_valid_o)
        else $error("valid kept after stall");
    a_stall_hold: assert property (s_stall |=> $stable(rx_payload_bus_o) && $stable(rx_byte_enables_o))
        else $error("beat changed in stall");
    a_sop_opens: assert property (rx_beat_valid_o && !in_pkt_ff |-> rx_first_beat_o)
        else $error("missing first marker");
    a_sop_inside: assert property (s_mid |-> !rx_first_beat_o)
        else $error("first marker inside packet");
    a_pkt_attr: assert property (s_mid |-> rx_window_hit_vector_o == bar_ff && rx_func_num_o == func_ff)
        else $error("hit vector or function moved");
    a_hdr4_beat: assert property (rx_beat_valid_o && in_pkt_ff && idx_ff == 2'd1 && hdr4_ff
        |-> !rx_byte_enables_o)
        else $error("be on second header beat");
    a_hdr3_beat: assert property (rx_beat_valid_o && in_pkt_ff && idx_ff == 2'd1 && !hdr4_ff
        |-> !rx_byte_enables_o[3:0])
        else $error("be on header dword two");
endmodule : trxsp_rx_port_props
bind trxsp_rx_port trxsp_rx_port_props u_props (.ref_clk_i, .nrst_i, .rx_payload_bus_o,
    .rx_byte_enables_o, .rx_beat_valid_o, .rx_first_beat_o, .rx_last_beat_o,
    .rx_window_hit_vector_o, .rx_func_num_o, .rx_sink_ready_i);

// >>> sim/trxsp_app_sink.sv
`timescale 1ns/100ps
module trxsp_app_sink (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic stall_en_i,
    input wire logic hold_i,
    output logic rx_sink_ready_o
);
    logic [7:0] lfsr_ff;
    // ready with random stall runs; ignores byte enables and takes back-to-back beats
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lfsr_ff <= 8'h5A;
            rx_sink_ready_o <= 1'b0;
        end else begin
            lfsr_ff <= {lfsr_ff[6:0], ^(lfsr_ff & 8'hB8)};
            rx_sink_ready_o <= !hold_i && (!stall_en_i || lfsr_ff[7]);
        end
    end
endmodule : trxsp_app_sink

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
    import trxsp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [31:0] dw = '0;
    logic dv = 1'b0;
    logic dl = 1'b0;
    logic [BAR_W-1:0] bar = '0;
    logic [FUNC_W-1:0] fn = '0;
    logic stall = 1'b0;
    logic hold = 1'b0;
    logic crdy;
    logic ov;
    logic srdy;
    logic [31:0] rng = 32'h0000_002A;
    trxsp_beat_s seen;
    trxsp_beat_s exp_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    // clock
    always #5 ref_clk_i = ~ref_clk_i;
    trxsp_rx_port dut (.ref_clk_i, .nrst_i, .core_dword_i(dw), .core_dword_valid_i(dv),
        .core_dword_last_i(dl), .core_bar_i(bar), .core_func_i(fn), .core_dword_ready_o(crdy),
        .rx_payload_bus_o(seen.data), .rx_byte_enables_o(seen.be), .rx_beat_valid_o(ov),
        .rx_first_beat_o(seen.sop), .rx_last_beat_o(seen.eop), .rx_window_hit_vector_o(seen.bar),
        .rx_func_num_o(seen.func), .rx_sink_ready_i(srdy));
    trxsp_app_sink u_sink (.ref_clk_i, .nrst_i, .stall_en_i(stall), .hold_i(hold),
        .rx_sink_ready_o(srdy));
    function automatic logic [31:0] nxt_rng(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : nxt_rng
    task automatic check(input string what, input logic [BEAT_W-1:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    // model the beats of one packet, then offer its dwords one by one
    task automatic send(input bit four, input bit wr, input logic [9:0] len, input bit a2);
        logic [31:0] d[$];
        trxsp_beat_s b;
        int n;
        int t;
        rng = nxt_rng(rng);
        b.bar = rng[7:0];
        b.func = rng[10:8];
        d = '{{1'b0, wr, four, 19'h0_0000, len}, {24'h00_0000, (len > 1) ? 4'hF : 4'h0, 4'hF}};
        if (four) d.push_back(rng);
        d.push_back({rng[31:3], a2, 2'b00});
        for (int k = 0; wr && k < len; k++) begin
            rng = nxt_rng(rng);
            d.push_back(rng);
        end
        n = d.size();
        for (int i = 0; i < n; i += 2) begin
            b.data = {(i + 1 < n) ? d[i+1] : 32'h0000_0000, d[i]};
            b.be = {(i + 1 < n && i + 4 > (four ? 6 : 5)) ? 4'hF : 4'h0, (i > (four ? 3 : 2)) ? 4'hF : 4'h0};
            b.sop = (i == 0);
            b.eop = (i + 2 >= n);
            exp_q.push_back(b);
        end
        foreach (d[k]) begin
            dw <= d[k];
            dl <= (k == n - 1);
            bar <= b.bar;
            fn <= b.func;
            dv <= 1'b1;
            for (t = 0; t < 300 && !(t > 0 && crdy === 1'b1); t++) @(negedge ref_clk_i);
            if (t >= 300) begin
                bad_count++;
                test_done();
            end
            @(posedge ref_clk_i);
        end
    endtask : send
    // compare each accepted beat with the model
    always @(negedge ref_clk_i) begin
        if (ov === 1'b1 && srdy === 1'b1) begin
            check("beat", seen, exp_q.size() ? exp_q.pop_front() : trxsp_beat_s'('x));
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        // fixed header forms back to back, then random packets with stalls
        send(1'b1, 1'b1, 10'd2, 1'b0);
        send(1'b0, 1'b1, 10'd3, 1'b1);
        send(1'b0, 1'b0, 10'd1, 1'b1);
        stall <= 1'b1;
        for (int p = 0; p < 40; p++) begin
            rng = nxt_rng(rng);
            send(rng[4], rng[5], {6'h00, rng[3:0]} + 10'd1, !rng[4]);
        end
        // sink held off: the fifo fills and refuses, then drains
        hold <= 1'b1;
        fork
            send(1'b0, 1'b1, 10'd40, 1'b1);
            begin
                repeat (60) @(negedge ref_clk_i);
                check("refuse", crdy, 1'b0);
                @(posedge ref_clk_i);
                hold <= 1'b0;
            end
        join
        dv <= 1'b0;
        for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge ref_clk_i);
        check("drained", exp_q.size(), 0);
        test_done();
    end
endmodule : tb
